// ---- inc/serial_card_cfg.svh ----
// Constants for the multiport serial card bus glue
`ifndef SERIAL_CARD_CFG_SVH
`define SERIAL_CARD_CFG_SVH
`define STD_BASE_PORT1   10'h3f8
`define STD_BASE_PORT2   10'h2f8
`define STD_BASE_PORT3   10'h3e8
`define STD_BASE_PORT4   10'h2e8
`define PORT_SPACING     10'h008
`define A9_FIXED_BIT     10'h200
`define ADDR_LSB         3
`define ADDR_MSB         9
`define FLAGS_RESET      8'h00
`define CLK_FAST_MULT    8
`define CLK_NORM_MULT    1
`endif

// ---- inc/serial_card_pkg.sv ----
// Types for the multiport serial card bus glue
package serial_card_pkg;
   typedef enum logic [0:0] {
      MODE_STANDARD = 1'b0,
      MODE_ENHANCED = 1'b1
   } card_mode_e;
   typedef enum logic [0:0] {
      IRQ_SHARED      = 1'b0,
      IRQ_INDEPENDENT = 1'b1
   } irq_mode_e;
endpackage : serial_card_pkg

// ---- testbench/isa_host_model.sv ----
// Host processor model driving I/O cycles into the card
`timescale 1ns/1ns
`default_nettype none
module isa_host_model (
   input  wire logic       clk_sys_i, // Bus clock
   output logic      [9:0] addr_o,    // I/O address
   output logic            ior_o,     // Read strobe
   output logic            iow_o,     // Write strobe
   output logic            aen_o      // DMA cycle
);
   initial begin
      addr_o = 10'h000;
      {ior_o, iow_o, aen_o} = 3'h0;
   end
   task start(input logic [9:0] a, input logic rd, input logic dma);
      @(posedge clk_sys_i);
      addr_o <= a;
      ior_o <= rd;
      iow_o <= !rd;
      aen_o <= dma;
   endtask : start
   // Released address shows its inverse so a stale match cannot pass
   task stop;
      @(posedge clk_sys_i);
      addr_o <= ~addr_o;
      {ior_o, iow_o, aen_o} <= 3'h0;
   endtask : stop
endmodule : isa_host_model
`default_nettype wire

// ---- testbench/serial_card_glue_asserts.sv ----
// Port-level checks of the serial card bus glue
`timescale 1ns/1ns
`default_nettype none
module serial_card_glue_asserts #(
   parameter int NPORTS = 8, // Ports fitted
   parameter int NLINES = 16 // Request lines
) (
   input wire logic clk_sys_i, // Clock
   input wire logic reset_i, // Reset
   input wire logic [9:0] bus_addr_i, // Address
   input wire logic bus_ior_i, // Read
   input wire logic bus_iow_i, // Write
   input wire logic bus_aen_i, // DMA
   input wire logic card_mode_sw_i, // Mode
   input wire logic irq_mode_sw_i, // Irq mode
   input wire logic speed_sw_i, // Speed
   input wire logic [NLINES-1:0] irq_level_jumper_bank_i, // Level
   input wire logic [4*NLINES-1:0] port_irq_jumper_i, // Port levels
   input wire logic [NPORTS-1:0] port_irq_i, // Requests
   input wire logic [NPORTS-1:0] port_sel_o, // Selects
   input wire logic status_sel_o, // Window hit
   input wire logic data_oe_o, // Drive
   input wire logic [7:0] bus_data_o, // Data
   input wire logic [NLINES-1:0] irq_o, // Lines
   input wire logic [3:0] baud_mult_o // Multiplier
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);
   sequence rd_std_p1;
      bus_ior_i && !bus_aen_i && !card_mode_sw_i && bus_addr_i[9:3] == 7'h7f;
   endsequence
   sel_strobe_a: assert property (|port_sel_o |-> $past((bus_ior_i ||
      bus_iow_i) && !bus_aen_i, 3)) else $error("select without cycle");
   oe_enh_a: assert property (data_oe_o |-> $past(bus_ior_i &&
      !bus_aen_i && card_mode_sw_i, 3)) else $error("bad drive");
   idle_data_a: assert property (!data_oe_o |-> bus_data_o == 8'h00)
      else $error("data while idle");
   status_bits_a: assert property (data_oe_o |->
      bus_data_o == $past(port_irq_i, 4)) else $error("status bits");
   status_sel_a: assert property (status_sel_o |-> $past((bus_ior_i ||
      bus_iow_i) && !bus_aen_i && card_mode_sw_i, 3))
      else $error("status select without cycle");
   oe_sel_a: assert property (data_oe_o |-> status_sel_o)
      else $error("drive outside status window");
   std_port1_a: assert property (rd_std_p1 ##3 1 |-> port_sel_o == 1)
      else $error("port one decode");
   std_upper_a: assert property ($past(!card_mode_sw_i, 3) |->
      port_sel_o[7:4] == 4'h0) else $error("upper port in standard");
   baud_fast_a: assert property (speed_sw_i [*5] |->
      baud_mult_o == 4'h8) else $error("baud fast");
   baud_norm_a: assert property (!speed_sw_i [*5] |->
      baud_mult_o == 4'h1) else $error("baud normal");
   shared_irq_a: assert property ($past(card_mode_sw_i && !irq_mode_sw_i
      && |port_irq_i, 4) |-> irq_o == $past(irq_level_jumper_bank_i, 4))
      else $error("shared line");
   indep_irq_a: assert property ($past(card_mode_sw_i && irq_mode_sw_i
      && port_irq_i == 2, 4) |-> irq_o == $past(port_irq_jumper_i[16+:16], 4))
      else $error("independent line");
   irq_quiet_a: assert property ($past(port_irq_i == 0, 4) |->
      irq_o == 0) else $error("line without request");
endmodule : serial_card_glue_asserts
bind serial_card_glue serial_card_glue_asserts #(.NPORTS(NPORTS),
   .NLINES(NLINES)) checker_i (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
   .bus_addr_i(bus_addr_i), .bus_ior_i(bus_ior_i), .bus_iow_i(bus_iow_i),
   .bus_aen_i(bus_aen_i), .card_mode_sw_i(card_mode_sw_i),
   .irq_mode_sw_i(irq_mode_sw_i), .speed_sw_i(speed_sw_i),
   .irq_level_jumper_bank_i(irq_level_jumper_bank_i),
   .port_irq_jumper_i(port_irq_jumper_i), .port_irq_i(port_irq_i),
   .port_sel_o(port_sel_o), .status_sel_o(status_sel_o),
   .data_oe_o(data_oe_o), .bus_data_o(bus_data_o),
   .irq_o(irq_o), .baud_mult_o(baud_mult_o));
`default_nettype wire

// ---- testbench/testbench.sv ----
// Self-checking bench of the serial card bus glue
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic clk_sys_i = 1'b0;
   logic reset_i = 1'b1;
   logic md = 1'b0, im = 1'b0, sp = 1'b0;
   logic [7:0] pirq = 8'h00;
   wire [9:0] addr;
   wire ior, iow, aen, ssel, oe;
   wire [7:0] sel, sel_b, dat;
   wire [15:0] irq;
   wire [3:0] baud;
   int bad_count = 0;
   int total_checks = 0;
   always #5 clk_sys_i = ~clk_sys_i;
   isa_host_model host (.clk_sys_i(clk_sys_i), .addr_o(addr), .ior_o(ior),
      .iow_o(iow), .aen_o(aen));
   // Base 300, status window 210, shared line 12, port two on line 3
   serial_card_glue dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
      .ce_i(1'b1), .bus_addr_i(addr), .bus_ior_i(ior), .bus_iow_i(iow),
      .bus_aen_i(aen), .port_base_switch_i(7'h1f),
      .vector_address_switch_i(7'h3d), .card_mode_sw_i(md),
      .irq_mode_sw_i(im), .speed_sw_i(sp),
      .irq_level_jumper_bank_i(16'h1000),
      .port_irq_jumper_i(64'h0000_0000_0008_0000), .port_irq_i(pirq),
      .port_sel_o(sel), .status_sel_o(ssel), .data_oe_o(oe),
      .bus_data_o(dat), .irq_o(irq), .baud_mult_o(baud));
   // Card without an A9 switch: A9 switch on must still decode at 300
   serial_card_glue #(.HAS_A9(1'b0)) dut_na9 (.clk_sys_i(clk_sys_i),
      .reset_i(reset_i), .ce_i(1'b1), .bus_addr_i(addr), .bus_ior_i(ior),
      .bus_iow_i(iow), .bus_aen_i(aen), .port_base_switch_i(7'h5f),
      .vector_address_switch_i(7'h3d), .card_mode_sw_i(md),
      .irq_mode_sw_i(im), .speed_sw_i(sp),
      .irq_level_jumper_bank_i(16'h1000),
      .port_irq_jumper_i(64'h0000_0000_0008_0000), .port_irq_i(pirq),
      .port_sel_o(sel_b), .status_sel_o(), .data_oe_o(), .bus_data_o(),
      .irq_o(), .baud_mult_o());
   task chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task cyc(input logic [9:0] a, input logic r, input logic dma,
            input logic [7:0] es, input logic [7:0] ed,
            input logic ess = 1'b0);
      host.start(a, r, dma);
      repeat (4) @(posedge clk_sys_i);
      #1;
      chk({8'h00, sel}, {8'h00, es});
      chk({8'h00, sel_b}, {8'h00, es});
      chk({8'h00, dat}, {8'h00, ed});
      chk({14'h0000, ssel, oe}, {14'h0000, ess, ess & r});
      host.stop;
      repeat (4) @(posedge clk_sys_i);
   endtask : cyc
   task settle;
      repeat (8) @(posedge clk_sys_i);
      #1;
   endtask : settle
   task give_verdict;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : give_verdict
   initial begin
      repeat (5) @(posedge clk_sys_i);
      reset_i <= 1'b0;
      settle;
      chk({12'h000, baud}, 16'h0001);
      cyc(10'h3f8, 1, 0, 8'h01, 8'h00);
      cyc(10'h2f8, 1, 0, 8'h02, 8'h00);
      cyc(10'h3e8, 1, 0, 8'h04, 8'h00);
      cyc(10'h2ef, 0, 0, 8'h08, 8'h00);
      cyc(10'h300, 1, 0, 8'h00, 8'h00);
      cyc(10'h210, 1, 0, 8'h00, 8'h00);
      $display("standard mode test done");
      md <= 1'b1;
      settle;
      for (int n = 0; n < 8; n++)
         cyc(10'h300 + 10'(9 * n), 1, 0, 8'h01 << n, 8'h00);
      cyc(10'h340, 1, 0, 8'h00, 8'h00);
      cyc(10'h2f8, 1, 0, 8'h00, 8'h00);
      $display("enhanced decode test done");
      pirq <= 8'ha5;
      settle;
      cyc(10'h210, 1, 0, 8'h00, 8'ha5, 1'b1);
      cyc(10'h217, 1, 0, 8'h00, 8'ha5, 1'b1);
      cyc(10'h217, 1, 0, 8'h00, 8'ha5, 1'b1);
      cyc(10'h218, 1, 0, 8'h00, 8'h00);
      cyc(10'h213, 1, 1, 8'h00, 8'h00);
      cyc(10'h213, 0, 0, 8'h00, 8'h00, 1'b1);
      #1;
      chk(irq, 16'h1000);
      @(posedge clk_sys_i);
      pirq <= 8'h00;
      settle;
      chk(irq, 16'h0000);
      $display("status and shared line test done");
      @(posedge clk_sys_i);
      im <= 1'b1;
      settle;
      @(posedge clk_sys_i);
      pirq <= 8'h02;
      settle;
      chk(irq, 16'h0008);
      @(posedge clk_sys_i);
      pirq <= 8'h00;
      sp <= 1'b1;
      settle;
      chk({12'h000, baud}, 16'h0008);
      $display("independent line and speed test done");
      give_verdict;
   end
endmodule : testbench
`default_nettype wire

// ---- verilog/serial_card_glue.sv ----
// Address decode, interrupt routing and status register of the serial card
//----------------------------------------------------------------------
// Summary of operation
//----------------------------------------------------------------------
// Summary of operation
// - Mode switch picks standard (fixed addresses) or enhanced mode card-wide.
// - Standard mode decodes ports 1-4 at 3F8, 2F8, 3E8, 2E8.
// - Enhanced mode: one common interrupt line in shared irq mode, plus a source status register.
// - Port n sits at switch base plus eight bytes times n-1.
// - Port base compares address lines A3..A9 with the base switches.
// - Without an A9 switch, A9 must be high (0x200 fixed).
// - Second mode switch picks shared (default) or independent interrupts in enhanced mode; standard mode is always independent.
// - Independent mode: ports 1-4 each drive their own selectable line.
// - Shared mode: all port interrupts combine onto one selectable level.
// - Received data raises that port's interrupt and its status bit.
// - Status bit n reads 1 while port n+1 requests interrupt.
// - Status register decodes a whole eight-byte window at its switches.
// - Speed switch selects 1x or 8x baud clock multiplier.
`timescale 1ns/1ns
`default_nettype none
`include "serial_card_cfg.svh"
module serial_card_glue #(
   parameter int NPORTS = 8,  // Ports fitted, 4 or 8
   parameter int NLINES = 16, // Bus interrupt request lines
   parameter bit HAS_A9 = 1'b1 // Base switch bank has an A9 switch
) (
   input  wire logic              clk_sys_i,      // Bus clock
   input  wire logic              reset_i,        // Sync reset
   input  wire logic              ce_i,           // Clock enable
   input  wire logic [9:0]        bus_addr_i,     // I/O address A0..A9
   input  wire logic              bus_ior_i,      // I/O read strobe
   input  wire logic              bus_iow_i,      // I/O write strobe
   input  wire logic              bus_aen_i,      // DMA cycle, blocks decode
   input  wire logic [6:0]        port_base_switch_i,     // On=1, A3..A9
   input  wire logic [6:0]        vector_address_switch_i, // On=1, A3..A9
   input  wire logic              card_mode_sw_i,  // 1: enhanced mode
   input  wire logic              irq_mode_sw_i,   // 1: independent irq
   input  wire logic              speed_sw_i,      // 1: 8x baud clock
   input  wire logic [NLINES-1:0] irq_level_jumper_bank_i, // Shared level
   input  wire logic [4*NLINES-1:0] port_irq_jumper_i, // Per-port levels
   input  wire logic [NPORTS-1:0] port_irq_i,      // Port cores request
   output logic      [NPORTS-1:0] port_sel_o,      // Port chip selects
   output logic                   status_sel_o,    // Status window hit
   output logic                   data_oe_o,       // Drive bus data
   output logic      [7:0]        bus_data_o,      // Read data
   output logic      [NLINES-1:0] irq_o,           // Bus request lines
   output logic      [3:0]        baud_mult_o      // Baud multiplier
);
   //-------------------------------------------------------------------
   // Pin synchronisation
   //-------------------------------------------------------------------
   localparam int SW = 7 + 7 + 3 + NLINES + 4*NLINES;
   logic [SW-1:0] sw_s;
   logic [NPORTS-1:0] irq_s;
   logic [9:0] addr_r;
   logic       ior_r;
   logic       iow_r;
   logic       aen_r;
   logic [6:0] pbase_s;
   logic [6:0] vbase_s;
   logic       mode_s;
   logic       irqm_s;
   logic       speed_s;
   logic [NLINES-1:0]   lvl_s;
   logic [4*NLINES-1:0] plvl_s;

   // Switches and jumpers are static, but still kept off the raw pins
   sync2 #(.W(SW)) u_sw_sync (
      .clk_sys_i (clk_sys_i),
      .reset_i   (reset_i),
      .ce_i      (ce_i),
      .d_i       ({port_base_switch_i, vector_address_switch_i,
                   card_mode_sw_i, irq_mode_sw_i, speed_sw_i,
                   irq_level_jumper_bank_i, port_irq_jumper_i}),
      .q_o       (sw_s)
   );
   assign {pbase_s, vbase_s, mode_s, irqm_s, speed_s, lvl_s, plvl_s} = sw_s;

   sync2 #(.W(NPORTS)) u_irq_sync (
      .clk_sys_i (clk_sys_i),
      .reset_i   (reset_i),
      .ce_i      (ce_i),
      .d_i       (port_irq_i),
      .q_o       (irq_s)
   );

   sync2 #(.W(13)) u_bus_sync (
      .clk_sys_i (clk_sys_i),
      .reset_i   (reset_i),
      .ce_i      (ce_i),
      .d_i       ({bus_addr_i, bus_ior_i, bus_iow_i, bus_aen_i}),
      .q_o       ({addr_r, ior_r, iow_r, aen_r})
   );

   //-------------------------------------------------------------------
   // Address decode
   //-------------------------------------------------------------------
   serial_card_pkg::card_mode_e card_mode;
   serial_card_pkg::irq_mode_e  irq_mode;
   assign card_mode = serial_card_pkg::card_mode_e'(mode_s);
   assign irq_mode  = serial_card_pkg::irq_mode_e'(irqm_s);

   // On switch means address bit must be zero
   function automatic logic [9:0] sw_to_base(input logic [6:0] sw);
      logic [9:0] b;
      b = {~sw, 3'b000};
      if (!HAS_A9)
         b = b | `A9_FIXED_BIT;
      return b;
   endfunction : sw_to_base

   logic [9:0] port_base;
   logic [9:0] vec_base;
   logic       cycle;
   assign port_base = sw_to_base(pbase_s);
   assign vec_base  = sw_to_base(vbase_s);
   assign cycle     = (ior_r | iow_r) & ~aen_r;

   logic [9:0] std_base [4];
   assign std_base[0] = `STD_BASE_PORT1;
   assign std_base[1] = `STD_BASE_PORT2;
   assign std_base[2] = `STD_BASE_PORT3;
   assign std_base[3] = `STD_BASE_PORT4;

   logic [NPORTS-1:0] port_hit;
   always_comb begin
      logic [9:0] enh_addr;
      enh_addr = '0;
      port_hit = '0;
      for (int i = 0; i < NPORTS; i++) begin
         // Wraps at 10 bits, as the bus does
         enh_addr = port_base + 10'(i) * `PORT_SPACING;
         if (card_mode == serial_card_pkg::MODE_STANDARD) begin
            if (i < 4)
               port_hit[i] = addr_r[9:3] == std_base[i][9:3];
         end else begin
            port_hit[i] = addr_r[9:3] == enh_addr[9:3];
         end
      end
   end

   logic status_hit;
   // Whole 8-byte window answers, A0..A2 ignored
   assign status_hit = (card_mode == serial_card_pkg::MODE_ENHANCED)
                     && (addr_r[9:3] == vec_base[9:3]);

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         port_sel_o   <= '0;
         status_sel_o <= 1'b0;
      end else if (ce_i) begin
         port_sel_o   <= cycle ? port_hit : '0;
         status_sel_o <= cycle & status_hit;
      end
   end

   //-------------------------------------------------------------------
   // Status register
   //-------------------------------------------------------------------
   logic [7:0] flags_r;
   // Live copy of port requests: a read never clears anything
   always_ff @(posedge clk_sys_i) begin
      if (reset_i)
         flags_r <= `FLAGS_RESET;
      else if (ce_i)
         flags_r <= 8'(irq_s);
   end

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         data_oe_o  <= 1'b0;
         bus_data_o <= 8'h00;
      end else if (ce_i) begin
         data_oe_o  <= ior_r & ~aen_r & status_hit;
         // A DMA cycle must never see status data on the bus
         bus_data_o <= (ior_r & ~aen_r & status_hit) ? flags_r
                                                     : 8'h00;
      end
   end

   //-------------------------------------------------------------------
   // Interrupt routing
   //-------------------------------------------------------------------
   logic [NLINES-1:0] irq_nxt;
   logic              any_irq;
   assign any_irq = |flags_r;
   always_comb begin
      irq_nxt = '0;
      if (card_mode == serial_card_pkg::MODE_STANDARD
          || irq_mode == serial_card_pkg::IRQ_INDEPENDENT) begin
         // Only the first four ports own a selectable line
         for (int p = 0; p < 4 && p < NPORTS; p++) begin
            if (flags_r[p])
               irq_nxt = irq_nxt | plvl_s[p*NLINES +: NLINES];
         end
      end else if (any_irq) begin
         irq_nxt = lvl_s;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (reset_i)
         irq_o <= '0;
      else if (ce_i)
         irq_o <= irq_nxt;
   end

   //-------------------------------------------------------------------
   // Baud clock multiplier
   //-------------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (reset_i)
         baud_mult_o <= 4'(`CLK_NORM_MULT);
      else if (ce_i)
         baud_mult_o <= speed_s ? 4'(`CLK_FAST_MULT)
                                : 4'(`CLK_NORM_MULT);
   end
endmodule : serial_card_glue
`default_nettype wire

// ---- verilog/sync2.sv ----
// Two-stage synchroniser for a bus of pin-level inputs
`timescale 1ns/1ns
`default_nettype none
module sync2 #(
   parameter int W = 1
) (
   input  wire logic         clk_sys_i, // System clock
   input  wire logic         reset_i,   // Sync reset, active high
   input  wire logic         ce_i,      // Clock enable
   input  wire logic [W-1:0] d_i,       // Asynchronous input
   output logic      [W-1:0] q_o        // Synchronised output
);
   logic [W-1:0] meta_r;
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         meta_r <= '0;
         q_o    <= '0;
      end else if (ce_i) begin
         meta_r <= d_i;
         q_o    <= meta_r;
      end
   end
endmodule : sync2
`default_nettype wire
